// File: logic/msu_pkg.sv
/*
 * Shared constants of the microcore shift unit: widths, instruction
 * field positions, opcode patterns, reset values and the state type.
 * Assumes a 16-bit instruction word and a 16-bit arithmetic register set.
 */
package msu_pkg;

    localparam int DATA_W     = 16;
    localparam int PROD_W     = 32;
    localparam int REG_COUNT  = 8;
    localparam int SEL_W      = 3;
    localparam int LIT_W      = 4;
    localparam int INSTR_W    = 16;

    // Instruction fields
    localparam int TGT_LSB    = 0;
    localparam int CNT_LSB    = 3;
    localparam int LIT_LSB    = 3;
    localparam logic [2:0] PROD_TAG = 3'h5;

    // Opcode patterns on bits 15:6, 15:7 and 15:3
    localparam logic [9:0]  OP_PROD_REG  = 10'h0E4;
    localparam logic [8:0]  OP_PROD_LIT  = 9'h070;
    localparam logic [9:0]  OP_SHL_REG   = 10'h0BA;
    localparam logic [12:0] OP_SHL_BYTE  = 13'h05DF;
    localparam logic [8:0]  OP_SHL_LIT   = 9'h05A;
    localparam logic [9:0]  OP_SHLS_REG  = 10'h0B8;
    localparam logic [8:0]  OP_SHLS_LIT  = 9'h058;
    localparam logic [9:0]  OP_SHR_REG   = 10'h0B9;
    localparam logic [12:0] OP_SHR_BYTE  = 13'h05DE;
    localparam logic [8:0]  OP_SHR_LIT   = 9'h059;
    localparam logic [9:0]  OP_SHRS_REG  = 10'h0B7;

    localparam int BYTE_SHIFT = 8;

    // Reset values and the count of one
    localparam logic [DATA_W-1:0] REG_RST   = 16'h0000;
    localparam logic [DATA_W-1:0] COUNT_ONE = 16'h0001;
    localparam logic              FLAG_RST  = 1'b0;

    typedef enum logic [1:0] {
        MSU_IDLE = 2'b00,
        MSU_RUN  = 2'b01
    } msu_state_type;

endpackage : msu_pkg

// File: logic/msu_dec_if.sv
/*
 * Decoded shift instruction passed from the decoder to the shift core.
 * Assumes both ends sit in the same clock domain; purely combinational.
 */
`timescale 1ns/1ps
interface msu_dec_if;
    logic                     hit;
    logic                     left;
    logic                     arith;
    logic                     product;
    logic                     byte_op;
    logic                     use_reg;
    logic [msu_pkg::SEL_W-1:0] tgt_sel;
    logic [msu_pkg::SEL_W-1:0] cnt_sel;
    logic [msu_pkg::LIT_W-1:0] lit;

    modport dec  (output hit, left, arith, product, byte_op, use_reg,
                         tgt_sel, cnt_sel, lit);
    modport core (input  hit, left, arith, product, byte_op, use_reg,
                         tgt_sel, cnt_sel, lit);
endinterface : msu_dec_if

// File: logic/msu_decode.sv
/*
 * Combinational decoder of the shift instructions.
 * Assumes the instruction word is stable while valid is high.
 */
`timescale 1ns/1ps
module msu_decode (
    // Instruction
    input  wire logic [msu_pkg::INSTR_W-1:0] instr,
    input  wire logic                        instr_valid,
    // Decoded fields
    msu_dec_if.dec                           dec
);
    import msu_pkg::*;

    wire [9:0]  top10 = instr[15:6];
    wire [8:0]  top9  = instr[15:7];
    wire [12:0] top13 = instr[15:3];
    wire        tag_ok = (instr[2:0] == PROD_TAG);

    wire is_prod_reg = (top10 == OP_PROD_REG) && tag_ok;
    wire is_prod_lit = (top9 == OP_PROD_LIT) && tag_ok;
    wire is_shl_reg  = (top10 == OP_SHL_REG);
    wire is_shl_byte = (top13 == OP_SHL_BYTE);
    wire is_shl_lit  = (top9 == OP_SHL_LIT);
    wire is_shls_reg = (top10 == OP_SHLS_REG);
    wire is_shls_lit = (top9 == OP_SHLS_LIT);
    wire is_shr_reg  = (top10 == OP_SHR_REG);
    wire is_shr_byte = (top13 == OP_SHR_BYTE);
    wire is_shr_lit  = (top9 == OP_SHR_LIT);
    wire is_shrs_reg = (top10 == OP_SHRS_REG);

    wire any_op = is_prod_reg | is_prod_lit | is_shl_reg | is_shl_byte |
                  is_shl_lit | is_shls_reg | is_shls_lit | is_shr_reg |
                  is_shr_byte | is_shr_lit | is_shrs_reg;

    assign dec.hit     = instr_valid && any_op;
    assign dec.left    = is_shl_reg | is_shl_byte | is_shl_lit |
                         is_shls_reg | is_shls_lit;
    assign dec.arith   = is_shls_reg | is_shls_lit | is_shrs_reg;
    assign dec.product = is_prod_reg | is_prod_lit;
    assign dec.byte_op = is_shl_byte | is_shr_byte;
    assign dec.use_reg = is_prod_reg | is_shl_reg | is_shls_reg |
                         is_shr_reg | is_shrs_reg;
    assign dec.tgt_sel = instr[TGT_LSB +: SEL_W];
    assign dec.cnt_sel = instr[CNT_LSB +: SEL_W];
    assign dec.lit     = instr[LIT_LSB +: LIT_W];

endmodule : msu_decode

// File: logic/msu_step.sv
/*
 * One-position shifter with shifted-out bit and overflow indication.
 * Assumes WIDTH of at least 3; purely combinational.
 */
`timescale 1ns/1ps
module msu_step #(
    parameter int WIDTH = 16
) (
    // Operand and mode
    input  wire logic [WIDTH-1:0] data,
    input  wire logic             left,
    input  wire logic             arith,
    // Result
    output logic      [WIDTH-1:0] result,
    output logic                  out_bit,
    output logic                  ovf
);
    wire sign = data[WIDTH-1];

    wire [WIDTH-1:0] left_arith  = {sign, data[WIDTH-3:0], 1'b0};
    wire [WIDTH-1:0] left_log    = {data[WIDTH-2:0], 1'b0};
    wire [WIDTH-1:0] right_arith = {sign, data[WIDTH-1:1]};
    wire [WIDTH-1:0] right_log   = {1'b0, data[WIDTH-1:1]};

    // Signed left loses bit below the sign; mismatch means overflow
    wire left_out = arith ? data[WIDTH-2] : data[WIDTH-1];

    assign result  = left ? (arith ? left_arith : left_log)
                          : (arith ? right_arith : right_log);
    assign out_bit = left ? left_out : data[0];
    assign ovf     = left && (arith ? (left_out != sign) : left_out);

endmodule : msu_step

// File: logic/msu_shift_unit.sv
/*
 * Shift unit of the microcore arithmetic unit: holds the arithmetic
 * register set and the product pair, runs bit shifts one position
 * per clock and byte shifts in one clock, keeps the shift condition flags.
 * Assumes the decoder stage holds the instruction while busy_q is high.
 */
`timescale 1ns/1ps
// Function
// - product pair is upper then lower
// - product shift by register, cycles count
// - product right shift by literal
// - right shifts update precision loss flag
// - logical left by register, cycles count
// - left byte shift in one cycle
// - right byte shift in one cycle
// - logical left by literal count
// - signed shifts keep the sign bit
// - signed left shift by literal
// - logical right by register, cycles count
// - logical right by literal count
// - signed right shift by register
// - left shifts update overflow flag
// - literal shifts take literal cycles
// - operands come from arithmetic registers, product shifts from the product pair
module msu_shift_unit (
    // Clock and reset
    input  wire logic                         clk,
    input  wire logic                         reset_n,
    // Instruction issue
    input  wire logic [msu_pkg::INSTR_W-1:0]  instr,
    input  wire logic                         instr_valid,
    // Register set write and read port
    input  wire logic                         reg_wr_en,
    input  wire logic [msu_pkg::SEL_W-1:0]    reg_wr_sel,
    input  wire logic [msu_pkg::DATA_W-1:0]   reg_wr_data,
    input  wire logic [msu_pkg::SEL_W-1:0]    reg_rd_sel,
    output logic      [msu_pkg::DATA_W-1:0]   reg_rd_data_q,
    // Product pair load and view
    input  wire logic                         prod_wr_en,
    input  wire logic [msu_pkg::PROD_W-1:0]   prod_wr_data,
    output logic      [msu_pkg::DATA_W-1:0]   product_upper_q,
    output logic      [msu_pkg::DATA_W-1:0]   product_lower_q,
    // Status
    output logic                              busy_q,
    output logic                              done_q,
    output logic                              shifted_out_flag_q,
    output logic                              overflow_flag_q,
    output logic                              precision_loss_flag_q
);
    import msu_pkg::*;

    msu_dec_if dec ();

    msu_decode u_decode (
        .instr       (instr),
        .instr_valid (instr_valid),
        .dec         (dec)
    );

    msu_state_type           state_q;
    msu_state_type           state_d;
    logic [DATA_W-1:0]       arith_register_set_q [REG_COUNT];
    logic [DATA_W-1:0]       arith_register_set_d [REG_COUNT];
    logic [DATA_W-1:0]       remain_q;
    logic [DATA_W-1:0]       remain_d;
    logic [SEL_W-1:0]        tgt_q;
    logic                    left_q;
    logic                    arith_q;
    logic                    prod_q;
    logic [DATA_W-1:0]       upper_d;
    logic [DATA_W-1:0]       lower_d;
    logic                    shout_d;
    logic                    ovf_d;
    logic                    loss_d;

    wire accept   = dec.hit && !busy_q;
    wire running  = (state_q == MSU_RUN);

    wire [SEL_W-1:0] tgt_idx = running ? tgt_q : dec.tgt_sel;
    wire left_now  = running ? left_q  : dec.left;
    wire arith_now = running ? arith_q : dec.arith;
    wire prod_now  = running ? prod_q  : dec.product;

    wire [DATA_W-1:0] reg_operand = arith_register_set_q[tgt_idx];
    wire [PROD_W-1:0] prod_operand = {product_upper_q, product_lower_q};

    wire [DATA_W-1:0] lit_count = {{(DATA_W-LIT_W){1'b0}}, dec.lit};
    wire [DATA_W-1:0] count_val = dec.use_reg ?
                                  arith_register_set_q[dec.cnt_sel] :
                                  lit_count;
    wire zero_cnt = (count_val == REG_RST);

    // Single-position shifters for the register and the product pair
    wire [DATA_W-1:0] reg_next;
    wire              reg_out;
    wire              reg_ovf;
    wire [PROD_W-1:0] prod_next;
    wire              prod_out;

    msu_step #(
        .WIDTH (DATA_W)
    ) u_step_reg (
        .data    (reg_operand),
        .left    (left_now),
        .arith   (arith_now),
        .result  (reg_next),
        .out_bit (reg_out),
        .ovf     (reg_ovf)
    );

    // Product pair only ever shifts right, logically
    msu_step #(
        .WIDTH (PROD_W)
    ) u_step_prod (
        .data    (prod_operand),
        .left    (1'b0),
        .arith   (1'b0),
        .result  (prod_next),
        .out_bit (prod_out),
        .ovf     ()
    );

    wire step_out = prod_now ? prod_out : reg_out;

    wire [DATA_W-1:0] byte_left_val = {reg_operand[BYTE_SHIFT-1:0],
                                       {BYTE_SHIFT{1'b0}}};
    wire [DATA_W-1:0] byte_right_val = {{BYTE_SHIFT{1'b0}},
                                        reg_operand[DATA_W-1:BYTE_SHIFT]};
    wire [DATA_W-1:0] byte_val  = dec.left ? byte_left_val : byte_right_val;
    wire byte_out  = dec.left ? reg_operand[BYTE_SHIFT] :
                                reg_operand[BYTE_SHIFT-1];
    wire byte_ovf  = |reg_operand[DATA_W-1:BYTE_SHIFT];
    wire byte_loss = |reg_operand[BYTE_SHIFT-1:0];

    wire byte_now  = accept && dec.byte_op;
    wire do_step   = running || (accept && !dec.byte_op && !zero_cnt);
    wire reg_write = (do_step && !prod_now) || byte_now;
    wire prod_write = do_step && prod_now;
    wire [DATA_W-1:0] shift_val = byte_now ? byte_val : reg_next;

    // Finishes now: single-cycle ops or the final position
    wire last_run  = running && (remain_q == COUNT_ONE);
    wire first_fin = accept && (dec.byte_op || zero_cnt ||
                                (count_val == COUNT_ONE));
    wire finish    = first_fin || last_run;

    // Sign bit seen by the step, kept for checking
    wire sign_bit  = reg_operand[DATA_W-1];

    always_comb begin
        state_d  = state_q;
        remain_d = remain_q;
        if (accept && !dec.byte_op && !zero_cnt) begin
            remain_d = count_val - COUNT_ONE;
            state_d  = (count_val == COUNT_ONE) ? MSU_IDLE : MSU_RUN;
        end else if (running) begin
            remain_d = remain_q - COUNT_ONE;
            state_d  = last_run ? MSU_IDLE : MSU_RUN;
        end
    end

    // Shift write wins over a core write to the same register
    always_comb begin
        for (int i = 0; i < REG_COUNT; i++) begin
            arith_register_set_d[i] = arith_register_set_q[i];
            if (reg_write && (tgt_idx == SEL_W'(i))) begin
                arith_register_set_d[i] = shift_val;
            end else if (reg_wr_en && !busy_q &&
                         (reg_wr_sel == SEL_W'(i))) begin
                arith_register_set_d[i] = reg_wr_data;
            end
        end
    end

    // product pair written back each step
    always_comb begin
        upper_d = product_upper_q;
        lower_d = product_lower_q;
        if (prod_write) begin
            upper_d = prod_next[PROD_W-1:DATA_W];
            lower_d = prod_next[DATA_W-1:0];
        end else if (prod_wr_en && !busy_q) begin
            upper_d = prod_wr_data[PROD_W-1:DATA_W];
            lower_d = prod_wr_data[DATA_W-1:0];
        end
    end

    // Shifted-out flag and the flag of the direction restart with each instruction; overflow and loss accumulate per step
    always_comb begin
        shout_d = shifted_out_flag_q;
        ovf_d   = overflow_flag_q;
        loss_d  = precision_loss_flag_q;
        if (accept) begin
            shout_d = dec.byte_op ? byte_out : (zero_cnt ? 1'b0 : step_out);
            if (dec.left) begin
                ovf_d = dec.byte_op ? byte_ovf : (!zero_cnt && reg_ovf);
            end else begin
                loss_d = dec.byte_op ? byte_loss : (!zero_cnt && step_out);
            end
        end else if (running) begin
            shout_d = step_out;
            if (left_q) begin
                ovf_d = overflow_flag_q | reg_ovf;
            end else begin
                loss_d = precision_loss_flag_q | step_out;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_q  <= MSU_IDLE;
            busy_q   <= 1'b0;
            remain_q <= REG_RST;
        end else begin
            state_q  <= state_d;
            busy_q   <= (state_d == MSU_RUN);
            remain_q <= remain_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tgt_q   <= '0;
            left_q  <= 1'b0;
            arith_q <= 1'b0;
            prod_q  <= 1'b0;
        end else if (accept) begin
            tgt_q   <= dec.tgt_sel;
            left_q  <= dec.left;
            arith_q <= dec.arith;
            prod_q  <= dec.product;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < REG_COUNT; i++) begin
                arith_register_set_q[i] <= REG_RST;
            end
            product_upper_q <= REG_RST;
            product_lower_q <= REG_RST;
        end else begin
            arith_register_set_q <= arith_register_set_d;
            product_upper_q      <= upper_d;
            product_lower_q      <= lower_d;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            shifted_out_flag_q    <= FLAG_RST;
            overflow_flag_q       <= FLAG_RST;
            precision_loss_flag_q <= FLAG_RST;
            done_q                <= 1'b0;
            reg_rd_data_q         <= REG_RST;
        end else begin
            shifted_out_flag_q    <= shout_d;
            overflow_flag_q       <= ovf_d;
            precision_loss_flag_q <= loss_d;
            done_q                <= finish;
            reg_rd_data_q         <= arith_register_set_q[reg_rd_sel];
        end
    end

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    a_byte_left: assert property (
        accept && dec.byte_op && dec.left |=>
            !busy_q && done_q &&
            arith_register_set_q[$past(tgt_idx)] == $past(byte_left_val))
        else $error("left byte shift result or timing wrong");

    a_byte_right: assert property (
        accept && dec.byte_op && !dec.left |=>
            !busy_q && done_q &&
            arith_register_set_q[$past(tgt_idx)] == $past(byte_right_val))
        else $error("right byte shift result or timing wrong");

    a_lit_cycles: assert property (
        accept && !dec.use_reg && !dec.byte_op && count_val == 16'h0005 |=>
            busy_q [*4] ##1 (!busy_q && done_q))
        else $error("literal shift did not take its count in cycles");

    a_reg_cycles: assert property (
        accept && dec.use_reg && count_val == 16'h0004 |=>
            busy_q [*3] ##1 (!busy_q && done_q))
        else $error("register-count shift took wrong cycle count");

    a_sign_kept: assert property (
        do_step && arith_now && !prod_now |=>
            arith_register_set_q[$past(tgt_idx)][DATA_W-1] ==
            $past(sign_bit))
        else $error("signed shift changed the sign bit");

    a_loss_flag: assert property (
        running && !left_q && step_out |=> precision_loss_flag_q)
        else $error("precision loss not flagged on right shift");

    a_ovf_flag: assert property (
        running && left_q && reg_ovf |=> overflow_flag_q)
        else $error("overflow not flagged on left shift");

    a_shout_flag: assert property (
        do_step |=> shifted_out_flag_q == $past(step_out))
        else $error("shifted-out flag not the last bit out");

    a_prod_right: assert property (
        running && prod_q |=>
            {product_upper_q, product_lower_q} == $past(prod_next))
        else $error("product pair not shifted right by one");

    // Offered writes must not disturb a running register shift
    a_issue_stall: assert property (
        busy_q |=> $stable(tgt_q) &&
            (prod_q || ($stable(product_upper_q) &&
                        $stable(product_lower_q))))
        else $error("instruction or write taken during a running shift");

endmodule : msu_shift_unit

// File: verif/tb_msu_shift_unit.sv
/*
 * Self-checking bench of the microcore shift unit: literal, register,
 * byte and product shifts, refused writes while busy, back-to-back ops.
 * Assumes the msu_pkg constants and a single 125 MHz clock domain.
 */
`timescale 1ns/1ps
module tb_msu_shift_unit;
    import msu_pkg::*;

    logic               clk = 1'b0;
    logic               reset_n = 1'b0;
    logic [INSTR_W-1:0] instr = 16'h0000;
    logic               instr_valid = 1'b0;
    logic               reg_wr_en = 1'b0;
    logic [SEL_W-1:0]   reg_wr_sel = 3'h0;
    logic [DATA_W-1:0]  reg_wr_data = 16'h0000;
    logic [SEL_W-1:0]   reg_rd_sel = 3'h0;
    logic [DATA_W-1:0]  reg_rd_data_q;
    logic               prod_wr_en = 1'b0;
    logic [PROD_W-1:0]  prod_wr_data = 32'h0000_0000;
    logic [DATA_W-1:0]  product_upper_q;
    logic [DATA_W-1:0]  product_lower_q;
    logic               busy_q;
    logic               done_q;
    logic               shifted_out_flag_q;
    logic               overflow_flag_q;
    logic               precision_loss_flag_q;
    logic               exp_ov = 1'b0;
    logic               exp_pl = 1'b0;
    int                 fail_count = 0;
    int                 tests_run = 0;

    always #4 clk = ~clk;

    msu_shift_unit u_msu_shift_unit (
        .clk(clk), .reset_n(reset_n), .instr(instr),
        .instr_valid(instr_valid), .reg_wr_en(reg_wr_en),
        .reg_wr_sel(reg_wr_sel), .reg_wr_data(reg_wr_data),
        .reg_rd_sel(reg_rd_sel), .reg_rd_data_q(reg_rd_data_q),
        .prod_wr_en(prod_wr_en), .prod_wr_data(prod_wr_data),
        .product_upper_q(product_upper_q),
        .product_lower_q(product_lower_q), .busy_q(busy_q),
        .done_q(done_q), .shifted_out_flag_q(shifted_out_flag_q),
        .overflow_flag_q(overflow_flag_q),
        .precision_loss_flag_q(precision_loss_flag_q)
    );

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude;
        $display("Comparisons %0d, mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : conclude

    // Kinds: 0 logical left, 1 signed left, 2 logical right, 3 signed right
    function automatic logic model(input int kind, input int n,
                                   inout logic [DATA_W-1:0] v);
        logic sb;
        logic ob;
        sb = 1'b0;
        ob = 1'b0;
        // Flag of the direction restarts at each issue
        if (kind < 2) exp_ov = 1'b0;
        else exp_pl = 1'b0;
        for (int i = 0; i < n; i++) begin
            case (kind)
                0: begin ob = v[15]; v = v << 1; end
                1: begin
                    ob = v[14];
                    if (v[14] != v[15]) exp_ov = 1'b1;
                    v = {v[15], v[13:0], 1'b0};
                end
                2: begin ob = v[0]; v = v >> 1; end
                default: begin ob = v[0]; v = {v[15], v[15:1]}; end
            endcase
            if (kind == 0 && ob) exp_ov = 1'b1;
            if (kind >= 2 && ob) exp_pl = 1'b1;
            sb = ob;
        end
        return sb;
    endfunction : model

    task automatic wr_reg(input logic [2:0] sel, input logic [15:0] d);
        reg_wr_en = 1'b1; reg_wr_sel = sel; reg_wr_data = d;
        @(posedge clk); #1;
        reg_wr_en = 1'b0;
        // One idle edge so back-to-back writes never toggle in one step
        @(posedge clk);
        #1;
    endtask : wr_reg

    task automatic rd_reg(input logic [2:0] sel, output logic [15:0] d);
        reg_rd_sel = sel;
        @(posedge clk); #1;
        d = reg_rd_data_q;
    endtask : rd_reg

    task automatic load_prod(input logic [31:0] d);
        prod_wr_en = 1'b1; prod_wr_data = d;
        @(posedge clk); #1;
        prod_wr_en = 1'b0;
        check({product_upper_q, product_lower_q}, d);
    endtask : load_prod

    task automatic issue(input logic [15:0] w, output int cyc, output int bsy);
        cyc = 0; bsy = 0; instr = w; instr_valid = 1'b1;
        do begin
            @(posedge clk); #1;
            instr_valid = 1'b0;
            cyc++;
            if (busy_q === 1'b1) bsy++;
        end while (done_q !== 1'b1 && cyc < 40);
    endtask : issue

    task automatic run_op(input logic [15:0] w, input int kind,
                          input logic [2:0] tgt, input logic [15:0] tval,
                          input int n, input bit one);
        logic [15:0] v;
        logic [15:0] got;
        logic sb;
        int cyc, bsy, ce;
        v = tval;
        sb = model(kind, n, v);
        ce = (one || n == 0) ? 1 : n;
        wr_reg(tgt, tval);
        issue(w, cyc, bsy);
        check(cyc, ce);
        check(bsy, ce - 1);
        check(shifted_out_flag_q, sb);
        check(overflow_flag_q, exp_ov);
        check(precision_loss_flag_q, exp_pl);
        rd_reg(tgt, got);
        check(got, v);
    endtask : run_op

    task automatic t_reset;
        logic [15:0] got;
        check({busy_q, done_q, shifted_out_flag_q, overflow_flag_q,
               precision_loss_flag_q}, 0);
        check({product_upper_q, product_lower_q}, 0);
        for (int i = 0; i < REG_COUNT; i++) begin
            rd_reg(3'(i), got);
            check(got, REG_RST);
        end
    endtask : t_reset

    task automatic t_literal;
        logic [8:0] ops [3] = '{OP_SHL_LIT, OP_SHLS_LIT, OP_SHR_LIT};
        int lits [4] = '{0, 1, 7, 15};
        for (int k = 0; k < 3; k++)
            for (int j = 0; j < 4; j++)
                run_op({ops[k], 4'(lits[j]), 3'(j + 2)}, k, 3'(j + 2),
                       16'hB5A3 ^ 16'(lits[j] << 4), lits[j], 1'b0);
    endtask : t_literal

    task automatic t_register;
        logic [9:0] ops [4] = '{OP_SHL_REG, OP_SHLS_REG, OP_SHR_REG,
                                OP_SHRS_REG};
        int cnts [3] = '{1, 4, 15};
        for (int k = 0; k < 4; k++)
            for (int j = 0; j < 3; j++) begin
                wr_reg(3'h6, 16'(cnts[j]));
                run_op({ops[k], 3'h6, 3'h2}, k, 3'h2, 16'h96C3, cnts[j], 1'b0);
            end
    endtask : t_register

    task automatic t_byte;
        run_op({OP_SHL_BYTE, 3'h3}, 0, 3'h3, 16'h12F0, 8, 1'b1);
        run_op({OP_SHR_BYTE, 3'h4}, 2, 3'h4, 16'h8381, 8, 1'b1);
        run_op({OP_SHR_BYTE, 3'h0}, 2, 3'h0, 16'hA500, 8, 1'b1);
    endtask : t_byte

    task automatic t_product(input int n, input bit lit);
        logic [31:0] p;
        logic sb;
        int cyc, bsy;
        p = 32'hC0DE_7A31;
        sb = 1'b0;
        exp_pl = 1'b0;
        for (int i = 0; i < n; i++) begin
            sb = p[0];
            if (p[0]) exp_pl = 1'b1;
            p = p >> 1;
        end
        wr_reg(3'h3, 16'(n));
        load_prod(32'hC0DE_7A31);
        if (lit) issue({OP_PROD_LIT, 4'(n), PROD_TAG}, cyc, bsy);
        else issue({OP_PROD_REG, 3'h3, PROD_TAG}, cyc, bsy);
        check(cyc, n == 0 ? 1 : n);
        check({product_upper_q, product_lower_q}, p);
        check(shifted_out_flag_q, sb);
        check(precision_loss_flag_q, exp_pl);
        check(overflow_flag_q, exp_ov);
    endtask : t_product

    task automatic t_refuse;
        logic [15:0] v;
        logic [15:0] got;
        logic sb;
        int cyc;
        v = 16'h0F0F;
        sb = model(2, 5, v);
        load_prod(32'h8001_4002);
        wr_reg(3'h1, 16'h0F0F);
        instr = {OP_SHR_LIT, 4'h5, 3'h1};
        instr_valid = 1'b1;
        @(posedge clk); #1;
        check(busy_q, 1'b1);
        // Everything offered now must be dropped while busy
        reg_wr_en = 1'b1; reg_wr_sel = 3'h1; reg_wr_data = 16'hFFFF;
        prod_wr_en = 1'b1; prod_wr_data = 32'h0000_0000;
        instr = {OP_SHL_BYTE, 3'h1};
        @(posedge clk); #1;
        reg_wr_en = 1'b0; prod_wr_en = 1'b0; instr_valid = 1'b0;
        cyc = 2;
        while (done_q !== 1'b1 && cyc < 40) begin
            @(posedge clk); #1;
            cyc++;
        end
        check(cyc, 5);
        check(shifted_out_flag_q, sb);
        check(precision_loss_flag_q, exp_pl);
        check({product_upper_q, product_lower_q}, 32'h8001_4002);
        rd_reg(3'h1, got);
        check(got, v);
    endtask : t_refuse

    task automatic t_back2back;
        logic [15:0] v;
        logic [15:0] got;
        logic sb;
        v = 16'h1234;
        sb = model(0, 8, v);
        sb = model(2, 8, v);
        wr_reg(3'h5, 16'h1234);
        instr = {OP_SHL_BYTE, 3'h5};
        instr_valid = 1'b1;
        @(posedge clk); #1;
        instr = {OP_SHR_BYTE, 3'h5};
        @(posedge clk); #1;
        instr_valid = 1'b0;
        check(done_q, 1'b1);
        check(shifted_out_flag_q, sb);
        check(overflow_flag_q, exp_ov);
        check(precision_loss_flag_q, exp_pl);
        rd_reg(3'h5, got);
        check(got, v);
    endtask : t_back2back

    initial begin
        #(8 * 30000);
        fail_count++;
        conclude();
    end

    initial begin
        repeat (12) @(posedge clk);
        #1;
        reset_n = 1'b1;
        t_reset();
        t_literal();
        t_register();
        t_byte();
        t_product(5, 1'b0);
        t_product(0, 1'b0);
        t_product(15, 1'b1);
        t_refuse();
        t_back2back();
        conclude();
    end
endmodule : tb_msu_shift_unit
